// File: hw/kbdgp_gen.sv
`timescale 1ns/1ps
`default_nettype none
module kbdgp_gen (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire logic                          tick_i,
   input  wire logic                          pin_i,
   input  wire kbdgp_pkg::kbdgp_gen_cfg_t     cfg_i,
   input  wire logic [kbdgp_pkg::DEB_W-1:0]   debounce_ms_i,
   input  wire logic                          clr_i,
   output logic                               irq_o,
   output kbdgp_pkg::kbdgp_gen_state_t        state_o
);

   logic                        key_hit;
   logic [kbdgp_pkg::DEB_W-1:0] cnt_r;

   // Polarity 0 means the high level is active
   assign key_hit = pin_i ^ cfg_i.polarity;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_o <= kbdgp_pkg::G_IDLE;
         cnt_r   <= '0;
         irq_o   <= 1'b0;
      end else begin
         case (state_o)
            kbdgp_pkg::G_IDLE: begin
               if (key_hit && !cfg_i.deb_en) begin
                  irq_o   <= 1'b1;
                  state_o <= kbdgp_pkg::G_FLAG;
               end else if (key_hit) begin
                  cnt_r   <= debounce_ms_i;
                  state_o <= kbdgp_pkg::G_DEB;
               end
            end
            kbdgp_pkg::G_DEB: begin
               if (!key_hit) begin
                  state_o <= kbdgp_pkg::G_IDLE;
               end else if (cnt_r == '0) begin
                  irq_o   <= 1'b1;
                  state_o <= kbdgp_pkg::G_FLAG;
               end else if (tick_i) begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            kbdgp_pkg::G_FLAG: begin
               // Flag is only set outside this state, so a clear never races a set
               if (clr_i) begin
                  irq_o   <= 1'b0;
                  state_o <= cfg_i.edge_mode ? kbdgp_pkg::G_WAIT_REL : kbdgp_pkg::G_IDLE;
               end
            end
            kbdgp_pkg::G_WAIT_REL: begin
               // Software may flip polarity here to catch the other edge
               if (!key_hit) begin
                  state_o <= kbdgp_pkg::G_IDLE;
               end
            end
            default: begin
               state_o <= kbdgp_pkg::G_IDLE;
               irq_o   <= 1'b0;
            end
         endcase
      end
   end

endmodule // kbdgp_gen
`default_nettype wire

// File: hw/kbdgp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module kbdgp_sync #(
   parameter int unsigned W = 12
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   always_ff @(posedge clk_i) begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
   end

   // A bit moves only once the last two stages agree
   genvar i;
   for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            q_o[i] <= 1'b0;
         end else if (s2_r[i] == s3_r[i]) begin
            q_o[i] <= s3_r[i];
         end
      end
   end

endmodule // kbdgp_sync
`default_nettype wire

// File: hw/kbdgp_top.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Level 0 and pin enabled: falling edge sets keyboard key-hit and starts sequencer.
// - Keyboard key-hit loads debounce value, counter decrements once per millisecond tick.
// - Counter at zero with key still held reloads repeat value, interrupting each expiry.
// - Key release with release option set runs a new debounce, then interrupts.
// - Keyboard debounce enable at 0 bypasses the keyboard debounce counter.
// - Repeat value 0 gives no repeated interrupts while the key stays pressed.
// - Keyboard active level is programmable; release option 0 suppresses release interrupt.
// - Twelve per-pin keyboard enables; only enabled pins take part in detection.
// - Debounce time is programmable from 0 to 63 ms in 1 ms steps.
// - Five identical pin generators, each with own interrupt line and source select.
// - Generator polarity 0 makes a rising edge the active event; polarity programmable.
// - Generator loads debounce, counts per ms, interrupts if still active at zero.
// - Each generator has its own debounce enable; cleared bit disables its counter.
// - Generator flag stays set until software writes its bit in the clear register.
// - Edge mode: clearing moves to wait-for-release, idle only after the inactive edge.
// - Keyboard interrupt is a separate output from the five generator lines.
module kbdgp_top #(
   parameter int unsigned TICK_CYCLES = kbdgp_pkg::TICK_CYCLES
) (
   input  wire logic                            clk_i,
   input  wire logic                            rst_i,
   input  wire logic                            wb_cyc_i,
   input  wire logic                            wb_stb_i,
   input  wire logic                            wb_we_i,
   input  wire logic [kbdgp_pkg::ADR_W-1:0]     wb_adr_i,
   input  wire logic [3:0]                      wb_sel_i,
   input  wire logic [31:0]                     wb_dat_i,
   output logic      [31:0]                     wb_dat_o,
   output logic                                 wb_ack_o,
   input  wire logic [kbdgp_pkg::NUM_PINS-1:0]  pins_i,
   output logic                                 keyboard_irq_o,
   output logic      [kbdgp_pkg::NUM_GEN-1:0]   pin_irq_line_o
);

   localparam int unsigned NP = kbdgp_pkg::NUM_PINS;
   localparam int unsigned NG = kbdgp_pkg::NUM_GEN;
   localparam int unsigned DW = kbdgp_pkg::DEB_W;
   localparam int unsigned SW = kbdgp_pkg::SEL_W;

   // Configuration words
   logic [31:0] debounce_r;
   logic [31:0] kb_cfg_r;
   logic [31:0] pin_cfg_r;
   logic [31:0] pin_sel_r;
   logic [NG-1:0] clr_r;

   // Bus handshake
   logic        wb_req;
   logic        wb_take;
   logic [31:0] rd_data;

   // Synchronised pins and tick
   logic [NP-1:0] pins_sync;
   logic [31:0]   tick_cnt_r;
   logic          tick_r;

   // Decoded fields
   logic [DW-1:0] debounce_ms;
   logic          kb_debounce_en;
   logic [NG-1:0] pin_irq_debounce_en;
   logic [NP-1:0] kb_pin_enable;
   logic          kb_active_level;
   logic          kb_release_irq_en;
   logic [DW-1:0] kb_repeat_ms;
   logic [NG-1:0] pin_irq_polarity;
   logic [NG-1:0] pin_irq_edge_mode;

   // Keyboard sequencer
   kbdgp_pkg::kbdgp_kb_state_t kb_state_r;
   logic [DW-1:0]              kb_cnt_r;
   logic                       kb_hit;
   logic [DW-1:0]              kb_deb_load;

   // Generator outputs
   logic [NG-1:0] gen_irq;

   function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel,
                                            input logic [31:0] mask);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      wb_merge = res & mask;
   endfunction

   // Field extraction
   assign debounce_ms         = debounce_r[kbdgp_pkg::DEBOUNCE_MS_LSB +: DW];
   assign kb_debounce_en      = debounce_r[kbdgp_pkg::KB_DEB_EN_BIT];
   assign pin_irq_debounce_en = debounce_r[kbdgp_pkg::PIN_DEB_EN_LSB +: NG];
   assign kb_pin_enable       = kb_cfg_r[kbdgp_pkg::KB_PIN_EN_LSB +: NP];
   assign kb_active_level     = kb_cfg_r[kbdgp_pkg::KB_LEVEL_BIT];
   assign kb_release_irq_en   = kb_cfg_r[kbdgp_pkg::KB_REL_BIT];
   assign kb_repeat_ms        = kb_cfg_r[kbdgp_pkg::KB_REPEAT_LSB +: DW];
   assign pin_irq_polarity    = pin_cfg_r[kbdgp_pkg::PIN_POL_LSB +: NG];
   assign pin_irq_edge_mode   = pin_cfg_r[kbdgp_pkg::PIN_EDGE_LSB +: NG];

   // Pins come from outside the clock domain
   kbdgp_sync #(
      .W (NP)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (pins_i),
      .q_o   (pins_sync)
   );

   // Free-running millisecond tick; the first debounce step may be short
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b0;
      end else if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
         tick_r     <= 1'b0;
      end
   end

   // Wishbone slave: one wait state, ack for one cycle
   assign wb_req  = wb_cyc_i && wb_stb_i;
   assign wb_take = wb_req && !wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_take;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         debounce_r <= kbdgp_pkg::RST_CFG;
         kb_cfg_r   <= kbdgp_pkg::RST_CFG;
         pin_cfg_r  <= kbdgp_pkg::RST_CFG;
         pin_sel_r  <= kbdgp_pkg::RST_CFG;
      end else if (wb_take && wb_we_i) begin
         case (wb_adr_i)
            kbdgp_pkg::OFS_DEBOUNCE: begin
               debounce_r <= wb_merge(debounce_r, wb_dat_i, wb_sel_i, kbdgp_pkg::MASK_DEBOUNCE);
            end
            kbdgp_pkg::OFS_KB_CFG: begin
               kb_cfg_r <= wb_merge(kb_cfg_r, wb_dat_i, wb_sel_i, kbdgp_pkg::MASK_KB_CFG);
            end
            kbdgp_pkg::OFS_PIN_CFG: begin
               pin_cfg_r <= wb_merge(pin_cfg_r, wb_dat_i, wb_sel_i, kbdgp_pkg::MASK_PIN_CFG);
            end
            kbdgp_pkg::OFS_PIN_SEL: begin
               pin_sel_r <= wb_merge(pin_sel_r, wb_dat_i, wb_sel_i, kbdgp_pkg::MASK_PIN_SEL);
            end
            default: begin
            end
         endcase
      end
   end

   // Clear strobes last one cycle; writing 0 leaves a flag alone
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clr_r <= '0;
      end else if (wb_take && wb_we_i && wb_sel_i[0] && (wb_adr_i == kbdgp_pkg::OFS_IRQ_CLR)) begin
         clr_r <= wb_dat_i[NG-1:0];
      end else begin
         clr_r <= '0;
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      case (wb_adr_i)
         kbdgp_pkg::OFS_DEBOUNCE: rd_data = debounce_r;
         kbdgp_pkg::OFS_KB_CFG:   rd_data = kb_cfg_r;
         kbdgp_pkg::OFS_PIN_CFG:  rd_data = pin_cfg_r;
         kbdgp_pkg::OFS_PIN_SEL:  rd_data = pin_sel_r;
         kbdgp_pkg::OFS_IRQ_CLR: begin
            rd_data[NG-1:0] = gen_irq;
         end
         kbdgp_pkg::OFS_STATUS: begin
            rd_data[kbdgp_pkg::STAT_PIN_IRQ_LSB +: NG] = gen_irq;
            rd_data[kbdgp_pkg::STAT_KB_IRQ_BIT]        = keyboard_irq_o;
            rd_data[kbdgp_pkg::STAT_KB_ST_LSB +: 4]    = kb_state_r;
            rd_data[kbdgp_pkg::STAT_PINS_LSB +: NP]    = pins_sync;
         end
         default: rd_data = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_take) begin
         wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_data;
      end
   end

   // Any enabled pin at the active level holds key-hit
   assign kb_hit = |(kb_pin_enable & (kb_active_level ? pins_sync : ~pins_sync));
   // Bypass loads zero so the period ends on the next cycle
   assign kb_deb_load = kb_debounce_en ? debounce_ms : '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         kb_state_r     <= kbdgp_pkg::KB_IDLE;
         kb_cnt_r       <= '0;
         keyboard_irq_o <= 1'b0;
      end else begin
         keyboard_irq_o <= 1'b0;
         case (kb_state_r)
            kbdgp_pkg::KB_IDLE: begin
               if (kb_hit && !kb_debounce_en) begin
                  keyboard_irq_o <= 1'b1;
                  kb_cnt_r       <= kb_repeat_ms;
                  kb_state_r     <= kbdgp_pkg::KB_HELD;
               end else if (kb_hit) begin
                  kb_cnt_r   <= debounce_ms;
                  kb_state_r <= kbdgp_pkg::KB_PRESS;
               end
            end
            kbdgp_pkg::KB_PRESS: begin
               if (!kb_hit) begin
                  kb_state_r <= kbdgp_pkg::KB_IDLE;
               end else if (kb_cnt_r == '0) begin
                  keyboard_irq_o <= 1'b1;
                  kb_cnt_r       <= kb_repeat_ms;
                  kb_state_r     <= kbdgp_pkg::KB_HELD;
               end else if (tick_r) begin
                  kb_cnt_r <= kb_cnt_r - 1'b1;
               end
            end
            kbdgp_pkg::KB_HELD: begin
               if (!kb_hit && kb_release_irq_en) begin
                  kb_cnt_r   <= kb_deb_load;
                  kb_state_r <= kbdgp_pkg::KB_RELEASE;
               end else if (!kb_hit) begin
                  kb_state_r <= kbdgp_pkg::KB_IDLE;
               end else if (kb_repeat_ms == '0) begin
                  kb_cnt_r <= '0;
               end else if (kb_cnt_r == '0) begin
                  keyboard_irq_o <= 1'b1;
                  kb_cnt_r       <= kb_repeat_ms;
               end else if (tick_r) begin
                  kb_cnt_r <= kb_cnt_r - 1'b1;
               end
            end
            kbdgp_pkg::KB_RELEASE: begin
               // A new press during the release period is taken after it ends
               if (kb_cnt_r == '0) begin
                  keyboard_irq_o <= 1'b1;
                  kb_state_r     <= kbdgp_pkg::KB_IDLE;
               end else if (tick_r) begin
                  kb_cnt_r <= kb_cnt_r - 1'b1;
               end
            end
            default: begin
               kb_state_r <= kbdgp_pkg::KB_IDLE;
               kb_cnt_r   <= '0;
            end
         endcase
      end
   end

   // Pin interrupt generators
   genvar g;
   for (g = 0; g < NG; g++) begin : g_gen
      logic [SW-1:0]             src;
      logic                      src_pin;
      kbdgp_pkg::kbdgp_gen_cfg_t cfg;

      assign src     = pin_sel_r[SW*g +: SW];
      // Out-of-range selections watch a constant low input
      assign src_pin = (src < SW'(NP)) ? pins_sync[src] : 1'b0;
      assign cfg.polarity  = pin_irq_polarity[g];
      assign cfg.edge_mode = pin_irq_edge_mode[g];
      assign cfg.deb_en    = pin_irq_debounce_en[g];

      kbdgp_gen u_gen (
         .clk_i         (clk_i),
         .rst_i         (rst_i),
         .tick_i        (tick_r),
         .pin_i         (src_pin),
         .cfg_i         (cfg),
         .debounce_ms_i (debounce_ms),
         .clr_i         (clr_r[g]),
         .irq_o         (gen_irq[g]),
         .state_o       ()
      );
   end

   assign pin_irq_line_o = gen_irq;

endmodule // kbdgp_top
`default_nettype wire

// File: shared/kbdgp_pkg.sv
`default_nettype none
package kbdgp_pkg;

   // Clock and millisecond tick
   localparam int unsigned CLK_FREQ_HZ    = 50_000_000;
   localparam int unsigned TICK_PERIOD_US = 1000;
   localparam int unsigned TICK_CYCLES    = (CLK_FREQ_HZ / 1_000_000) * TICK_PERIOD_US;

   // Sizes
   localparam int unsigned NUM_PINS = 12;
   localparam int unsigned NUM_GEN  = 5;
   localparam int unsigned DEB_W    = 6;
   localparam int unsigned SEL_W    = 4;
   localparam int unsigned ADR_W    = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_DEBOUNCE = 8'h00;
   localparam logic [7:0] OFS_KB_CFG   = 8'h04;
   localparam logic [7:0] OFS_PIN_CFG  = 8'h08;
   localparam logic [7:0] OFS_PIN_SEL  = 8'h0c;
   localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
   localparam logic [7:0] OFS_STATUS   = 8'h14;

   // Field positions
   localparam int unsigned DEBOUNCE_MS_LSB    = 0;
   localparam int unsigned KB_DEB_EN_BIT    = 6;
   localparam int unsigned PIN_DEB_EN_LSB   = 8;
   localparam int unsigned KB_PIN_EN_LSB    = 0;
   localparam int unsigned KB_LEVEL_BIT     = 12;
   localparam int unsigned KB_REL_BIT       = 13;
   localparam int unsigned KB_REPEAT_LSB    = 16;
   localparam int unsigned PIN_POL_LSB      = 0;
   localparam int unsigned PIN_EDGE_LSB     = 8;
   localparam int unsigned STAT_PIN_IRQ_LSB = 0;
   localparam int unsigned STAT_KB_IRQ_BIT  = 5;
   localparam int unsigned STAT_KB_ST_LSB   = 8;
   localparam int unsigned STAT_PINS_LSB    = 16;

   // Writable bits and reset values
   localparam logic [31:0] MASK_DEBOUNCE = 32'h0000_1f7f;
   localparam logic [31:0] MASK_KB_CFG   = 32'h003f_3fff;
   localparam logic [31:0] MASK_PIN_CFG  = 32'h0000_1f1f;
   localparam logic [31:0] MASK_PIN_SEL  = 32'h000f_ffff;
   localparam logic [31:0] RST_CFG       = 32'h0000_0000;

   typedef struct packed {
      logic polarity;
      logic edge_mode;
      logic deb_en;
   } kbdgp_gen_cfg_t;

   typedef enum logic [3:0] {
      KB_IDLE    = 4'h1,
      KB_PRESS   = 4'h2,
      KB_HELD    = 4'h4,
      KB_RELEASE = 4'h8
   } kbdgp_kb_state_t;

   typedef enum logic [3:0] {
      G_IDLE     = 4'h1,
      G_DEB      = 4'h2,
      G_FLAG     = 4'h4,
      G_WAIT_REL = 4'h8
   } kbdgp_gen_state_t;

endpackage
`default_nettype wire

// File: tb/kbdgp_checker.sv
`timescale 1ns/1ps
`default_nettype none
module kbdgp_checker #(
   parameter int unsigned TICK_CYCLES = kbdgp_pkg::TICK_CYCLES
) (
   input wire logic                           clk_i,
   input wire logic                           rst_i,
   input wire logic                           wb_cyc_i,
   input wire logic                           wb_stb_i,
   input wire logic                           wb_we_i,
   input wire logic [kbdgp_pkg::ADR_W-1:0]    wb_adr_i,
   input wire logic [3:0]                     wb_sel_i,
   input wire logic [31:0]                    wb_dat_i,
   input wire logic [31:0]                    wb_dat_o,
   input wire logic                           wb_ack_o,
   input wire logic [kbdgp_pkg::NUM_PINS-1:0] pins_i,
   input wire logic                           keyboard_irq_o,
   input wire logic [kbdgp_pkg::NUM_GEN-1:0]  pin_irq_line_o
);
   logic       req_w;
   logic [4:0] clr_w;
   logic [4:0] clr_h1;
   logic [4:0] clr_h2;
   logic [4:0] clr_h3;
   assign req_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign clr_w = (req_w & wb_we_i & wb_sel_i[0] & (wb_adr_i == kbdgp_pkg::OFS_IRQ_CLR)) ? wb_dat_i[4:0] : 5'h00;
   // Clear takes two cycles to reach the flag; keep three for slack
   always_ff @(posedge clk_i) begin
      clr_h1 <= clr_w;
      clr_h2 <= clr_h1;
      clr_h3 <= clr_h2;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_answers: assert property (req_w |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_write_reads_zero: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0000_0000)
      else $error("write answer carries data");
   a_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h17 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && !keyboard_irq_o && pin_irq_line_o == 5'h00)
      else $error("outputs active after reset");
   a_kb_pulse: assert property (keyboard_irq_o |=> !keyboard_irq_o)
      else $error("keyboard interrupt not a pulse");
   a_flag_sticky: assert property (|($past(pin_irq_line_o) & ~pin_irq_line_o) |->
      (($past(pin_irq_line_o) & ~pin_irq_line_o) & ~(clr_h1 | clr_h2 | clr_h3)) == 5'h00)
      else $error("flag dropped without clear");
   a_flags_readback: assert property (wb_ack_o && !$past(wb_we_i) && ($past(wb_adr_i) == kbdgp_pkg::OFS_STATUS ||
      $past(wb_adr_i) == kbdgp_pkg::OFS_IRQ_CLR) |-> wb_dat_o[4:0] == $past(pin_irq_line_o))
      else $error("flag readback mismatch");
endmodule // kbdgp_checker
bind kbdgp_top kbdgp_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_i(pins_i),
   .keyboard_irq_o(keyboard_irq_o), .pin_irq_line_o(pin_irq_line_o));
`default_nettype wire

// File: tb/kbdgp_keys.sv
`timescale 1ns/1ps
`default_nettype none
module kbdgp_keys (
   input  wire logic        clk_i,
   input  wire logic [11:0] level_i,
   input  wire logic        bounce_i,
   output logic      [11:0] pins_o
);
   logic [11:0] last_r = 12'h000;
   logic [11:0] diff_r = 12'h000;
   logic [2:0]  chat_r = 3'h0;
   initial pins_o = 12'h000;
   // Contacts chatter a few cycles after each move when bounce is on
   always @(posedge clk_i) begin
      last_r <= level_i;
      if (level_i != last_r) begin
         diff_r <= level_i ^ last_r;
         chat_r <= bounce_i ? 3'h6 : 3'h0;
      end else if (chat_r != 3'h0) begin
         chat_r <= chat_r - 3'h1;
      end
      pins_o <= chat_r[0] ? (level_i ^ diff_r) : level_i;
   end
endmodule // kbdgp_keys
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int TICK = 20;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        keyboard_irq_o;
   logic [4:0]  pin_irq_line_o;
   logic [11:0] keys = 12'h000;
   logic [11:0] pins;
   logic        bounce = 1'b0;
   logic [4:0]  fl_q = 5'h00;
   int          error_cnt = 0;
   int          check_count = 0;
   int          kb_n = 0;
   int          falls = 0;
   int          cyc = 0;
   always #10 clk_i = ~clk_i;
   // Counters move on the falling edge so rising-edge readers never race them
   always @(negedge clk_i) begin
      cyc++;
      if (keyboard_irq_o === 1'b1) kb_n++;
      if (|(fl_q & ~pin_irq_line_o)) falls++;
      fl_q = pin_irq_line_o;
   end
   kbdgp_top #(.TICK_CYCLES(TICK)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .pins_i(pins), .keyboard_irq_o(keyboard_irq_o), .pin_irq_line_o(pin_irq_line_o));
   kbdgp_keys u_keys (.clk_i(clk_i), .level_i(keys), .bounce_i(bounce), .pins_o(pins));

   task automatic report_and_stop();
      if (error_cnt == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      check_count++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= wd;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      chk_rng("bus answer cycles", 2, 2, n);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] rd;
      wb_cycle(1'b1, adr, d, rd);
   endtask
   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      wb_cycle(1'b0, adr, 32'h0, rd);
      chk_val($sformatf("register %h", adr), exp, rd);
   endtask
   task automatic reg_rw(input logic [7:0] adr, input logic [31:0] wv, input logic [31:0] exp);
      wr(adr, wv);
      rd_chk(adr, exp);
      wr(adr, 32'h0);
   endtask
   task automatic wait_flag(input logic [4:0] m, input int maxc, output int dt);
      int t0;
      t0 = cyc;
      for (int i = 0; i < maxc && (pin_irq_line_o & m) == 5'h00; i++) @(posedge clk_i);
      dt = ((pin_irq_line_o & m) != 5'h00) ? cyc - t0 : -1;
   endtask
   task automatic wait_kb(input int maxc, output int dt);
      int n0;
      int t0;
      n0 = kb_n;
      t0 = cyc;
      for (int i = 0; i < maxc && kb_n == n0; i++) @(posedge clk_i);
      dt = (kb_n != n0) ? cyc - t0 : -1;
   endtask
   task automatic chk_flags(input logic [4:0] exp);
      chk_val("interrupt lines", {27'h0, exp}, {27'h0, pin_irq_line_o});
   endtask

   task automatic t_regs();
      for (int a = 0; a < 20; a += 4) rd_chk(8'(a), kbdgp_pkg::RST_CFG);
      rd_chk(kbdgp_pkg::OFS_STATUS, 32'h0000_0100);
      reg_rw(kbdgp_pkg::OFS_DEBOUNCE, 32'hffff_ffff, kbdgp_pkg::MASK_DEBOUNCE);
      reg_rw(kbdgp_pkg::OFS_KB_CFG, 32'hffff_ffff, kbdgp_pkg::MASK_KB_CFG);
      reg_rw(kbdgp_pkg::OFS_PIN_SEL, 32'hffff_ffff, kbdgp_pkg::MASK_PIN_SEL);
      reg_rw(kbdgp_pkg::OFS_PIN_CFG, 32'h0000_1f00, 32'h0000_1f00);
      reg_rw(8'h40, 32'hffff_ffff, 32'h0);
   endtask
   task automatic t_gen_edge();
      int dt;
      wr(kbdgp_pkg::OFS_PIN_SEL, 32'h0005_4321);
      wr(kbdgp_pkg::OFS_PIN_CFG, 32'h0000_1f00);
      for (int g = 0; g < 5; g++) begin
         keys[g+1] <= 1'b1;
         wait_flag(5'h1f, 20, dt);
         chk_rng("undebounced latency", 1, 8, dt);
         idle(20);
         chk_flags(5'(1 << g));
         wr(kbdgp_pkg::OFS_IRQ_CLR, 32'(1 << g));
         idle(10);
         chk_flags(5'h00);
         wr(kbdgp_pkg::OFS_PIN_CFG, 32'h0000_1f00 | 32'(1 << g));
         idle(10);
         chk_flags(5'h00);
         keys[g+1] <= 1'b0;
         wait_flag(5'h1f, 20, dt);
         chk_flags(5'(1 << g));
         wr(kbdgp_pkg::OFS_IRQ_CLR, 32'(1 << g));
         wr(kbdgp_pkg::OFS_PIN_CFG, 32'h0000_1f00);
         idle(10);
         chk_flags(5'h00);
      end
   endtask
   task automatic t_gen_level();
      int dt;
      int f0;
      wr(kbdgp_pkg::OFS_PIN_CFG, 32'h0);
      keys[1] <= 1'b1;
      wait_flag(5'h01, 20, dt);
      f0 = falls;
      wr(kbdgp_pkg::OFS_IRQ_CLR, 32'h1);
      idle(6);
      chk_rng("clear drops flag", 1, 1, falls - f0);
      chk_flags(5'h01);
      keys[1] <= 1'b0;
      idle(8);
      wr(kbdgp_pkg::OFS_IRQ_CLR, 32'h1);
      idle(10);
      chk_flags(5'h00);
   endtask
   task automatic t_gen_deb();
      int dt;
      wr(kbdgp_pkg::OFS_DEBOUNCE, 32'h0000_0103);
      bounce <= 1'b1;
      keys[1] <= 1'b1;
      idle(12);
      keys[1] <= 1'b0;
      idle(5 * TICK);
      chk_flags(5'h00);
      keys[1] <= 1'b1;
      wait_flag(5'h01, 5 * TICK, dt);
      chk_rng("pin debounce span", 2 * TICK, 3 * TICK + 12, dt);
      keys[1] <= 1'b0;
      wr(kbdgp_pkg::OFS_IRQ_CLR, 32'h1);
      idle(8);
      chk_flags(5'h00);
      bounce <= 1'b0;
   endtask
   task automatic t_kb_nodeb();
      int dt;
      int n0;
      wr(kbdgp_pkg::OFS_PIN_SEL, 32'h000f_ffff);
      wr(kbdgp_pkg::OFS_DEBOUNCE, 32'h0);
      keys <= 12'h180;
      idle(10);
      wr(kbdgp_pkg::OFS_KB_CFG, 32'h0000_0080);
      idle(10);
      n0 = kb_n;
      keys[8] <= 1'b0;
      idle(30);
      chk_rng("disabled pin pulses", 0, 0, kb_n - n0);
      keys[7] <= 1'b0;
      wait_kb(20, dt);
      chk_rng("undebounced key latency", 1, 8, dt);
      idle(4 * TICK);
      keys[7] <= 1'b1;
      idle(4 * TICK);
      chk_rng("key pulses", 1, 1, kb_n - n0);
   endtask
   task automatic t_kb_deb();
      int dt;
      int n0;
      wr(kbdgp_pkg::OFS_DEBOUNCE, 32'h0000_0042);
      wr(kbdgp_pkg::OFS_KB_CFG, 32'h0003_3004);
      keys[2] <= 1'b1;
      wait_kb(4 * TICK, dt);
      chk_rng("press debounce", TICK, 2 * TICK + 10, dt);
      repeat (2) begin
         wait_kb(5 * TICK, dt);
         chk_rng("repeat period", 3 * TICK, 3 * TICK, dt);
      end
      keys[2] <= 1'b0;
      wait_kb(4 * TICK, dt);
      chk_rng("release debounce", TICK, 2 * TICK + 10, dt);
      wr(kbdgp_pkg::OFS_KB_CFG, 32'h0000_1004);
      keys[2] <= 1'b1;
      wait_kb(4 * TICK, dt);
      n0 = kb_n;
      idle(8 * TICK);
      keys[2] <= 1'b0;
      idle(4 * TICK);
      chk_rng("pulses without repeat or release", 0, 0, kb_n - n0);
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_gen_edge();
      t_gen_level();
      t_gen_deb();
      t_kb_nodeb();
      t_kb_deb();
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
